// file: src/psv_supervisor.sv
// psv_supervisor: single-port power sourcing sequencer, fault timers,
// disconnect sensing, sense oscillator and register port.
// assumes all comparator flags and pins are synchronous to ref_clk.
`timescale 1ns/10ps
`include "psv_regs.svh"

module psv_supervisor #(
	parameter int TICK_CYCLES = `PSV_TICK_CYC,
	parameter int OSC_CYCLES  = `PSV_OSC_CYC
) (
	input  wire logic                ref_clk,
	input  wire logic                reset,
	input  wire logic [3:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic [31:0]              reg_rdata,
	input  wire psv_pkg::psv_flags_s flags,
	input  wire psv_pkg::psv_det_s   det,
	input  wire logic                alloc_over,
	input  wire logic                shutdown_n,
	input  wire logic                sine_osc_pin_i,
	output logic                     sine_osc_pin_o,
	output logic                     sine_osc_pin_oe,
	output logic                     det_start,
	output logic                     alloc_src,
	output logic                     port_on,
	output logic                     fast_off,
	output logic                     ilim_reduced,
	output logic                     regulator_en,
	output logic                     led_sink
);
	import psv_pkg::*;

	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
	localparam logic [19:0] OSC_LAST  = 20'(OSC_CYCLES - 1);
	localparam logic [19:0] OSC_HALF  = 20'(OSC_CYCLES / 2);

	psv_state_e  state_q;
	psv_led_e    led_code_q;
	logic [11:0] wait_q;
	logic [15:0] tick_cnt_q;
	logic        tick_q;
	logic        strap_done_q;
	logic        dc_mode_q;
	logic [19:0] osc_cnt_q;
	logic        sample_q;
	logic [1:0]  ctrl_q;
	logic [6:0]  ovl_cnt_q;
	logic [8:0]  dis_cnt_q;
	logic [4:0]  pres_cnt_q;
	logic        ac_low_q;
	logic        ac_good_q;
	logic        halt_req;
	logic        powered;
	logic        ovl_cond;
	logic        ovl_expire;
	logic        dis_cond;
	logic        dis_clear;
	logic        dis_expire;
	logic        midspan;

	// -----------------------------------------------------------------------
	// base tick and strap capture
	// -----------------------------------------------------------------------

	// one millisecond tick; every delay below counts these
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tick_cnt_q <= 16'h0000;
			tick_q     <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_LAST);
			if (tick_cnt_q == TICK_LAST)
				tick_cnt_q <= 16'h0000;
			else
				tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end

	// strap read once after release, while the pin is still undriven
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			strap_done_q <= 1'b0;
			dc_mode_q    <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			dc_mode_q    <= !sine_osc_pin_i;
		end
	end

	// -----------------------------------------------------------------------
	// sense oscillator
	// -----------------------------------------------------------------------

	// phase counter off the core clock, so sampling stays in lockstep
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			osc_cnt_q       <= 20'h0_0000;
			sample_q        <= 1'b0;
			sine_osc_pin_o  <= 1'b0;
			sine_osc_pin_oe <= 1'b0;
		end else begin
			sine_osc_pin_oe <= strap_done_q && !dc_mode_q;
			sine_osc_pin_o  <= (osc_cnt_q < OSC_HALF);
			sample_q        <= 1'b0;
			if (!strap_done_q || dc_mode_q) begin
				osc_cnt_q <= 20'h0_0000;
			end else if (osc_cnt_q == OSC_LAST) begin
				osc_cnt_q <= 20'h0_0000;
				sample_q  <= 1'b1;
			end else begin
				osc_cnt_q <= osc_cnt_q + 20'h0_0001;
			end
		end
	end

	// -----------------------------------------------------------------------
	// register port
	// -----------------------------------------------------------------------

	// control bits: midspan backoff and external logic supply
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			ctrl_q <= `PSV_CTRL_RST;
		else if (reg_wr && reg_addr == `PSV_ADDR_CTRL)
			ctrl_q <= reg_wdata[1:0];
	end

	assign midspan = ctrl_q[`PSV_CTRL_MIDSPAN];

	// read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= 32'h0000_0000;
			if (reg_rd && reg_addr == `PSV_ADDR_CTRL) begin
				reg_rdata[1:0] <= ctrl_q;
			end else if (reg_rd && reg_addr == `PSV_ADDR_STATUS) begin
				reg_rdata[`PSV_STAT_STATE_LSB +: 3] <= state_q;
				reg_rdata[`PSV_STAT_PORT_ON]        <= port_on;
				reg_rdata[`PSV_STAT_DC_MODE]        <= dc_mode_q;
				reg_rdata[`PSV_STAT_LED_LSB +: 3]   <= led_code_q;
				reg_rdata[`PSV_STAT_REG_EN]         <= regulator_en;
			end
		end
	end

	// -----------------------------------------------------------------------
	// fault and disconnect conditions
	// -----------------------------------------------------------------------
	assign halt_req = !shutdown_n || flags.overtemp;
	assign powered  = (state_q == ST_POWERED);
	// a severe fault is always above the cut level as well
	assign ovl_cond = flags.overload || flags.severe_fault;
	assign ovl_expire = powered && tick_q && ovl_cond &&
		(ovl_cnt_q == `PSV_OVLD_TK - 7'h01);
	assign dis_cond = dc_mode_q ? flags.undercurrent : ac_low_q;
	assign dis_clear = dc_mode_q ?
		(tick_q && !flags.undercurrent &&
			pres_cnt_q == `PSV_GLITCH_TK - 5'h01) :
		(sample_q && flags.ac_sense_pin && ac_good_q);
	assign dis_expire = powered && tick_q && dis_cond &&
		(dis_cnt_q == `PSV_MPDO_TK - 9'h001);

	// overload timer; any drop below cut restarts it
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			ovl_cnt_q <= 7'h00;
		else if (!powered || halt_req)
			ovl_cnt_q <= 7'h00;
		else if (!ovl_cond)
			ovl_cnt_q <= 7'h00;
		else if (tick_q)
			ovl_cnt_q <= ovl_cnt_q + 7'h01;
	end

	// presence filter: current must stay for the glitch window
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			pres_cnt_q <= 5'h00;
		else if (!powered || flags.undercurrent)
			pres_cnt_q <= 5'h00;
		else if (tick_q && pres_cnt_q != `PSV_GLITCH_TK - 5'h01)
			pres_cnt_q <= pres_cnt_q + 5'h01;
	end

	// ac samples: a low one arms counting, two good ones disarm
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ac_low_q  <= 1'b0;
			ac_good_q <= 1'b0;
		end else if (!powered) begin
			ac_low_q  <= 1'b0;
			ac_good_q <= 1'b0;
		end else if (sample_q) begin
			ac_good_q <= flags.ac_sense_pin;
			if (!flags.ac_sense_pin)
				ac_low_q <= 1'b1;
			else if (ac_good_q)
				ac_low_q <= 1'b0;
		end
	end

	// disconnect timer, shared by both sensing modes
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			dis_cnt_q <= 9'h000;
		else if (!powered || halt_req)
			dis_cnt_q <= 9'h000;
		else if (dis_clear)
			dis_cnt_q <= 9'h000;
		else if (tick_q && dis_cond)
			dis_cnt_q <= dis_cnt_q + 9'h001;
	end

	// -----------------------------------------------------------------------
	// port sequencer
	// -----------------------------------------------------------------------

	// halt outranks everything; every exit back to wait or detect reloads its backoff wait
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_q    <= ST_WAIT;
			wait_q     <= `PSV_STARTUP_TK;
			det_start  <= 1'b0;
			alloc_src  <= 1'b0;
			port_on    <= 1'b0;
			led_code_q <= LED_OFF;
		end else begin
			det_start <= 1'b0;
			if (halt_req) begin
				state_q   <= ST_HALT;
				port_on   <= 1'b0;
				alloc_src <= 1'b0;
				wait_q    <= `PSV_STARTUP_TK;
			end else begin
				case (state_q)
					ST_WAIT: begin
						if (wait_q == 12'h000) begin
							state_q   <= ST_DETECT;
							det_start <= 1'b1;
						end else if (tick_q) begin
							wait_q <= wait_q - 12'h001;
						end
					end
					ST_DETECT: begin
						if (det.done && det.code == DET_GOOD) begin
							state_q   <= ST_ALLOC;
							alloc_src <= 1'b1;
							wait_q    <= `PSV_SETTLE_TK;
						end else if (det.done) begin
							case (det.code)
								DET_LOW_R:  led_code_q <= LED_F1;
								DET_HIGH_R: led_code_q <= LED_F2;
								default:    led_code_q <= LED_OFF;
							endcase
							state_q   <= midspan ? ST_WAIT : ST_DETECT;
							wait_q    <= `PSV_MIDSPAN_TK;
							det_start <= !midspan;
						end
					end
					ST_ALLOC: begin
						if (wait_q != 12'h000) begin
							if (tick_q)
								wait_q <= wait_q - 12'h001;
						end else if (alloc_over) begin
							alloc_src  <= 1'b0;
							led_code_q <= LED_F9;
							state_q    <= midspan ? ST_WAIT : ST_DETECT;
							wait_q     <= `PSV_MIDSPAN_TK;
							det_start  <= !midspan;
						end else begin
							state_q    <= ST_POWERED;
							port_on    <= 1'b1;
							led_code_q <= LED_ON;
						end
					end
					ST_POWERED: begin
						if (ovl_expire) begin
							state_q    <= ST_WAIT;
							port_on    <= 1'b0;
							alloc_src  <= 1'b0;
							led_code_q <= LED_F5;
							wait_q     <= `PSV_STARTUP_TK;
						end else if (dis_expire) begin
							state_q    <= ST_WAIT;
							port_on    <= 1'b0;
							alloc_src  <= 1'b0;
							led_code_q <= LED_OFF;
							wait_q     <= `PSV_DISC_BK_TK;
						end
					end
					ST_HALT: begin
						state_q <= ST_WAIT;
						wait_q  <= `PSV_STARTUP_TK;
					end
					default: begin
						state_q <= ST_WAIT;
						wait_q  <= `PSV_STARTUP_TK;
					end
				endcase
			end
		end
	end

	// -----------------------------------------------------------------------
	// analog control outputs
	// -----------------------------------------------------------------------

	// gate kill follows a severe fault while powered; the limit loop then holds current
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			fast_off     <= 1'b0;
			ilim_reduced <= 1'b0;
			regulator_en <= 1'b0;
		end else begin
			fast_off     <= powered && flags.severe_fault;
			ilim_reduced <= flags.port_v_low;
			regulator_en <= !flags.overtemp;
		end
	end

	psv_led_drv u_led (
		.ref_clk    (ref_clk),
		.reset      (reset),
		.tick       (tick_q),
		.code       (led_code_q),
		.ext_supply (ctrl_q[`PSV_CTRL_EXT_SUPPLY]),
		.led_sink   (led_sink)
	);

	// -----------------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence halt_release_s;
		state_q == ST_HALT && !halt_req;
	endsequence

	sequence ovl_last_s;
		powered && tick_q && ovl_cond && ovl_cnt_q == 7'd61;
	endsequence

	fast_kill_a: assert property (
		powered && flags.severe_fault && !halt_req && !ovl_expire
		|=> fast_off && port_on)
		else $error("severe fault did not kill gate while powered");
	ovl_count_a: assert property (
		powered && !halt_req && tick_q && ovl_cond && ovl_cnt_q < 7'd61
		|=> ovl_cnt_q == 7'($past(ovl_cnt_q) + 7'h01))
		else $error("overload timer did not advance");
	ovl_expiry_a: assert property (
		ovl_last_s ##0 !halt_req
		|=> !port_on && led_code_q == LED_F5 && wait_q == 12'd4000)
		else $error("overload expiry did not remove power");
	ovl_clear_a: assert property (
		!ovl_cond |=> ovl_cnt_q == 7'h00)
		else $error("overload timer kept count after clear");
	fold_select_a: assert property (
		##1 ilim_reduced == $past(flags.port_v_low))
		else $error("foldback select does not follow port voltage");
	temp_halt_a: assert property (
		flags.overtemp |=> !regulator_en && !port_on && state_q == ST_HALT)
		else $error("overtemperature did not halt");
	halt_exit_a: assert property (
		halt_release_s ##1 !halt_req
		|-> state_q == ST_WAIT && wait_q == 12'd4000)
		else $error("release did not load the restart wait");
	dis_expiry_a: assert property (
		dis_expire && !halt_req && !ovl_expire
		|=> !port_on && wait_q == 12'd1500)
		else $error("disconnect expiry mishandled");
	osc_mode_a: assert property (
		strap_done_q && dc_mode_q |=> !sine_osc_pin_oe)
		else $error("oscillator driven in dc mode");
	sd_off_a: assert property (
		!shutdown_n [*2] |-> !port_on && !det_start)
		else $error("shutdown did not hold the port off");

endmodule // psv_supervisor

// file: src/psv_regs.svh
// psv_regs.svh: offsets, field positions, reset values and timing counts
// for the port supervisor; assumes a 50 MHz ref_clk and a 1 ms base tick.
`ifndef PSV_REGS_SVH
`define PSV_REGS_SVH

// ---------------------------------------------------------------------------
// clock and base tick
// ---------------------------------------------------------------------------
`define PSV_CLK_HZ           50000000
`define PSV_CLK_NS           20
`define PSV_TICK_US          1000
`define PSV_TICK_CYC         (`PSV_CLK_HZ / 1000000 * `PSV_TICK_US)

// ---------------------------------------------------------------------------
// delays in milliseconds and their counts in base ticks
// ---------------------------------------------------------------------------
`define PSV_STARTUP_MS       4000
`define PSV_MIDSPAN_MS       3200
`define PSV_DISC_BACKOFF_MS  1500
`define PSV_OVLD_MS          62
`define PSV_MPDO_MS          350
`define PSV_GLITCH_MS        20
`define PSV_ALLOC_SETTLE_MS  2
`define PSV_FLASH_PERIOD_MS  1200
`define PSV_FLASH_ON_MS      75
`define PSV_FLASH_GAP_MS     300

`define PSV_STARTUP_TK  12'(`PSV_STARTUP_MS * 1000 / `PSV_TICK_US)
`define PSV_MIDSPAN_TK  12'(`PSV_MIDSPAN_MS * 1000 / `PSV_TICK_US)
`define PSV_DISC_BK_TK  12'(`PSV_DISC_BACKOFF_MS * 1000 / `PSV_TICK_US)
`define PSV_SETTLE_TK   12'(`PSV_ALLOC_SETTLE_MS * 1000 / `PSV_TICK_US)
`define PSV_OVLD_TK     7'(`PSV_OVLD_MS * 1000 / `PSV_TICK_US)
`define PSV_MPDO_TK     9'(`PSV_MPDO_MS * 1000 / `PSV_TICK_US)
`define PSV_GLITCH_TK   5'(`PSV_GLITCH_MS * 1000 / `PSV_TICK_US)
`define PSV_FL_ON_TK    9'(`PSV_FLASH_ON_MS * 1000 / `PSV_TICK_US)
`define PSV_FL_GAP_TK   9'(`PSV_FLASH_GAP_MS * 1000 / `PSV_TICK_US)
`define PSV_FL_REST     4'(`PSV_FLASH_PERIOD_MS / `PSV_FLASH_GAP_MS)

// ---------------------------------------------------------------------------
// sense oscillator and led modulation
// ---------------------------------------------------------------------------
`define PSV_OSC_HZ           110
`define PSV_OSC_CYC          (`PSV_CLK_HZ / `PSV_OSC_HZ)
`define PSV_PWM_HZ           28000
`define PSV_PWM_LOW_NS       2200
`define PSV_PWM_PERIOD_CYC   11'(`PSV_CLK_HZ / `PSV_PWM_HZ)
`define PSV_PWM_LOW_CYC      11'(`PSV_PWM_LOW_NS / `PSV_CLK_NS)

// ---------------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------------
`define PSV_ADDR_CTRL        4'h0
`define PSV_ADDR_STATUS      4'h4
`define PSV_CTRL_RST         2'h0
`define PSV_CTRL_MIDSPAN     0
`define PSV_CTRL_EXT_SUPPLY  1
`define PSV_STAT_STATE_LSB   0
`define PSV_STAT_PORT_ON     3
`define PSV_STAT_DC_MODE     4
`define PSV_STAT_LED_LSB     5
`define PSV_STAT_REG_EN      8

`endif

// file: src/psv_pkg.sv
// psv_pkg: types shared by the port supervisor and its led driver;
// assumes psv_regs.svh supplies all numeric constants.
package psv_pkg;

	// -----------------------------------------------------------------------
	// states, gray coded along wait, detect, alloc, powered, halt
	// -----------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_WAIT    = 3'h0,
		ST_DETECT  = 3'h1,
		ST_ALLOC   = 3'h3,
		ST_POWERED = 3'h2,
		ST_HALT    = 3'h6
	} psv_state_e;

	typedef enum logic [2:0] {
		DET_GOOD  = 3'h0,
		DET_LOW_R = 3'h1,
		DET_HIGH_R = 3'h2,
		DET_OPEN  = 3'h3,
		DET_SHORT = 3'h4
	} psv_det_e;

	typedef enum logic [2:0] {
		LED_OFF = 3'h0,
		LED_ON  = 3'h1,
		LED_F1  = 3'h2,
		LED_F2  = 3'h3,
		LED_F5  = 3'h4,
		LED_F9  = 3'h5
	} psv_led_e;

	// -----------------------------------------------------------------------
	// carriers
	// -----------------------------------------------------------------------
	typedef struct packed {
		logic severe_fault;
		logic overload;
		logic port_v_low;
		logic overtemp;
		logic undercurrent;
		logic ac_sense_pin;
	} psv_flags_s;

	typedef struct packed {
		logic     done;
		psv_det_e code;
	} psv_det_s;

endpackage

// file: src/psv_led_drv.sv
// psv_led_drv: led flash-code sequencer and low-side pwm drive;
// assumes a one-cycle base tick every millisecond from the supervisor.
`timescale 1ns/10ps
`include "psv_regs.svh"

module psv_led_drv (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              tick,
	input  wire psv_pkg::psv_led_e code,
	input  wire logic              ext_supply,
	output logic                   led_sink
);
	import psv_pkg::*;

	logic [8:0]  pos_q;
	logic [3:0]  slot_q;
	logic [3:0]  flashes;
	logic [10:0] pwm_q;
	psv_led_e    code_q;
	logic        lit;

	// flashes per code
	always_comb begin
		case (code)
			LED_F1: flashes = 4'h1;
			LED_F2: flashes = 4'h2;
			LED_F5: flashes = 4'h5;
			LED_F9: flashes = 4'h9;
			default: flashes = 4'h0;
		endcase
	end

	// frame of flash slots plus three quiet slots; restarts on a new code
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pos_q  <= 9'h000;
			slot_q <= 4'h0;
			code_q <= LED_OFF;
		end else begin
			code_q <= code;
			if (code != code_q) begin
				pos_q  <= 9'h000;
				slot_q <= 4'h0;
			end else if (tick) begin
				if (pos_q == `PSV_FL_GAP_TK - 9'h001) begin
					pos_q <= 9'h000;
					if (slot_q == flashes + `PSV_FL_REST - 4'h2)
						slot_q <= 4'h0;
					else
						slot_q <= slot_q + 4'h1;
				end else begin
					pos_q <= pos_q + 9'h001;
				end
			end
		end
	end

	// steady on while the code is LED_ON, which a halt leaves set; flash slots otherwise
	assign lit = (code == LED_ON) ||
		((slot_q < flashes) && (pos_q < `PSV_FL_ON_TK));

	// 28 khz carrier; wraps at the period
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			pwm_q <= 11'h000;
		else if (pwm_q == `PSV_PWM_PERIOD_CYC - 11'h001)
			pwm_q <= 11'h000;
		else
			pwm_q <= pwm_q + 11'h001;
	end

	// internal supply pulses the sink, external supply holds it
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			led_sink <= 1'b0;
		else
			led_sink <= lit && (ext_supply ||
				(pwm_q < `PSV_PWM_LOW_CYC));
	end

endmodule // psv_led_drv

// file: sim/psv_pd_model.sv
// psv_pd_model: behavioural powered device at the far end of the port;
// assumes the bench sets its signature and load level.
`timescale 1ns/10ps
module psv_pd_model (
	input  wire logic              ref_clk,
	input  wire logic              reset,
	input  wire logic              det_start,
	input  wire logic              port_on,
	input  wire psv_pkg::psv_det_e sig,
	input  wire logic              draw,
	input  wire logic              overdraw,
	output psv_pkg::psv_det_s      det,
	output logic                   undercurrent,
	output logic                   overload
);
	import psv_pkg::*;
	logic [3:0] wait_q;
	// signature answers ten cycles after each probe; the oscillator pin
	// is never driven from this side
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wait_q <= 4'h0;
			det    <= '0;
		end else begin
			det.done <= (wait_q == 4'h1);
			det.code <= sig;
			wait_q   <= det_start ? 4'hA :
				(wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
		end
	end
	// load is only seen while the port is powered
	assign undercurrent = port_on & ~draw;
	assign overload     = port_on & overdraw;
endmodule // psv_pd_model

// file: sim/tb_top.sv
// tb_top: scenario bench for the port supervisor and its device;
// assumes the dc strap and a base tick shortened to two cycles.
`timescale 1ns/10ps
module tb_top;
	import psv_pkg::*;
	localparam int T = 2;
	logic        ref_clk, reset, reg_wr, reg_rd, shutdown_n, osc_i;
	logic        alloc_over, draw, overdraw, port_v_low, overtemp, uc, ol;
	logic        det_start, alloc_src, port_on, ilim_reduced;
	logic        regulator_en, led_sink, sev, fast_off;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	psv_flags_s  flags;
	psv_det_s    det;
	psv_det_e    sig;
	int          failures, checked, n;

	assign flags = {sev, ol, port_v_low, overtemp, uc, 1'b0};

	psv_supervisor #(.TICK_CYCLES(T), .OSC_CYCLES(40)) u_dut (
		.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .flags(flags), .det(det),
		.alloc_over(alloc_over), .shutdown_n(shutdown_n),
		.sine_osc_pin_i(osc_i), .sine_osc_pin_o(), .sine_osc_pin_oe(),
		.det_start(det_start), .alloc_src(alloc_src), .port_on(port_on),
		.fast_off(fast_off), .ilim_reduced(ilim_reduced),
		.regulator_en(regulator_en), .led_sink(led_sink));

	psv_pd_model u_pd (
		.ref_clk(ref_clk), .reset(reset), .det_start(det_start),
		.port_on(port_on), .sig(sig), .draw(draw), .overdraw(overdraw),
		.det(det), .undercurrent(uc), .overload(ol));

	// free-running 50 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// status word with regulator on and the dc strap in place
	function automatic logic [31:0] st(psv_state_e s, logic on, psv_led_e l);
		return {23'h0, 1'b1, l, 1'b1, on, s};
	endfunction

	// w 2 waits for a detection start, 0 or 1 for that port level
	task automatic waitc(input int w, input int lim);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (!((w == 2) ? det_start === 1'b1 : port_on === w[0])
			&& n < lim);
	endtask

	// led sink cycles over one full modulation period
	task automatic cnt(input int exp);
		n = 0;
		repeat (1785) @(negedge ref_clk) n += (led_sink === 1'b1);
		chk(n, exp);
	endtask

	task automatic end_of_test;
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog: the whole sequence needs about 32000 cycles
	initial begin
		repeat (90000) @(posedge ref_clk);
		failures++;
		end_of_test;
	end

	initial begin
		{reg_wr, reg_rd, osc_i, alloc_over, overdraw, sev} = '0;
		{port_v_low, overtemp, reg_addr, reg_wdata} = '0;
		{reset, shutdown_n, draw} = 3'b111;
		failures = 0;
		checked = 0;
		sig = DET_LOW_R;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		rd(4'h4, st(ST_WAIT, 1'b0, LED_OFF));
		rd(4'h0, 32'h0000_0000);
		rd(4'h8, 32'h0000_0000);
		waitc(2, 9000);
		chk(n > 4000 * T - 10, 1);
		waitc(2, 100);
		chk(n < 100, 1);
		rd(4'h4, st(ST_DETECT, 1'b0, LED_F1));
		@(posedge ref_clk) sig <= DET_HIGH_R;
		waitc(2, 100);
		waitc(2, 100);
		rd(4'h4, st(ST_DETECT, 1'b0, LED_F2));
		@(posedge ref_clk) {sig, alloc_over} <= {DET_GOOD, 1'b1};
		waitc(2, 100);
		waitc(2, 200);
		chk(port_on, 1'b0);
		chk(alloc_src, 1'b0);
		rd(4'h4, st(ST_DETECT, 1'b0, LED_F9));
		@(posedge ref_clk) alloc_over <= 1'b0;
		waitc(1, 300);
		rd(4'h4, st(ST_POWERED, 1'b1, LED_ON));
		@(posedge ref_clk) port_v_low <= 1'b1;
		repeat (3) @(negedge ref_clk);
		chk(ilim_reduced, 1'b1);
		@(posedge ref_clk) port_v_low <= 1'b0;
		cnt(110);
		wr(4'h0, 32'h0000_0002);
		rd(4'h0, 32'h0000_0002);
		cnt(1785);
		wr(4'h0, 32'h0000_0000);
		@(posedge ref_clk) overdraw <= 1'b1;
		repeat (40 * T) @(posedge ref_clk);
		overdraw <= 1'b0;
		repeat (4) @(negedge ref_clk);
		chk(port_on, 1'b1);
		// a short severe fault kills the gate but keeps the port up
		@(posedge ref_clk) sev <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({fast_off, port_on}, 2'b11);
		@(posedge ref_clk) sev <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk({fast_off, port_on}, 2'b01);
		@(posedge ref_clk) overdraw <= 1'b1;
		waitc(0, 300);
		chk(n >= 62 * T - 4 && n <= 62 * T + 4, 1);
		rd(4'h4, st(ST_WAIT, 1'b0, LED_F5));
		@(posedge ref_clk) overdraw <= 1'b0;
		waitc(2, 9000);
		chk(n > 3990 * T && n < 4010 * T, 1);
		waitc(1, 300);
		@(posedge ref_clk) draw <= 1'b0;
		repeat (300 * T) @(posedge ref_clk);
		draw <= 1'b1;
		repeat (10 * T) @(posedge ref_clk);
		draw <= 1'b0;
		waitc(0, 1000);
		chk(n <= 52 * T, 1);
		waitc(2, 4000);
		chk(n > 1490 * T && n < 1510 * T, 1);
		@(posedge ref_clk) draw <= 1'b1;
		waitc(1, 300);
		@(posedge ref_clk) shutdown_n <= 1'b0;
		repeat (2) @(negedge ref_clk);
		chk(port_on, 1'b0);
		@(posedge ref_clk) shutdown_n <= 1'b1;
		waitc(2, 9000);
		chk(n > 3990 * T && n < 4010 * T, 1);
		@(posedge ref_clk) overtemp <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk(regulator_en, 1'b0);
		@(posedge ref_clk) overtemp <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk(regulator_en, 1'b1);
		end_of_test;
	end
endmodule // tb_top
